// ===== verilog/aos_sequencer.sv
`timescale 1ns/1ps
module aos_sequencer import aos_pkg::*; #(
  parameter int            DEPTH       = 16,
  parameter int            HAS_CURRENT = 1,
  parameter logic [DW-1:0] ZERO_CODE   = 16'h0000
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_n_i,
  input  wire logic [5:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic                  trig24_i,
  input  wire logic                  sync_trig_i,
  input  wire logic [NCH-1:0]        fault_i,
  output aos_dac_type [NCH-1:0]      dac_o,
  output logic      [NCH-1:0]        dac_update_o,
  output logic                       irq_o
);
  localparam int IW = $clog2(DEPTH);

  // ==========================================================================
  // Helpers
  function automatic int tab_at(input logic [2:0] ch, input logic [IW-1:0] ix);
    return int'(ch) * DEPTH + int'(ix);
  endfunction

  function automatic logic pick_trig(input logic src_sync, input logic t24, input logic sy);
    return src_sync ? sy : t24;
  endfunction

  // ==========================================================================
  // State
  logic                  ack_ff, nxt_ack;
  logic [31:0]           rdata_ff, nxt_rdata;
  logic [1:0]            rel_ff, nxt_rel;
  logic [1:0]            wdu_ff, nxt_wdu;
  logic                  wden_ff, nxt_wden;
  logic [WDW-1:0]        wdper_ff, nxt_wdper;
  logic [WDW-1:0]        wdcnt_ff, nxt_wdcnt;
  logic [7:0]            pre_us_ff, nxt_pre_us;
  logic [9:0]            pre_ms_ff, nxt_pre_ms;
  logic [9:0]            pre_s_ff, nxt_pre_s;
  logic [15:0]           rate_ff, nxt_rate;
  logic [15:0]           rcnt_ff, nxt_rcnt;
  logic [NCH-1:0]        cont_ff, nxt_cont;
  logic [NCH-1:0]        pace_ff, nxt_pace;
  logic                  src_ff, nxt_src;
  logic [NCH-1:0]        omode_ff, nxt_omode;
  logic [2:0]            tch_ff, nxt_tch;
  logic [IW-1:0]         tix_ff, nxt_tix;
  logic [IW-1:0]         last_ff [NCH], nxt_last [NCH];
  logic [STW-1:0]        stat_ff, nxt_stat;
  logic [STW-1:0]        mask_ff, nxt_mask;
  logic [NCH-1:0]        pmask_ff, nxt_pmask;
  logic [DW-1:0]         pval_ff [NCH], nxt_pval [NCH];
  logic [DW-1:0]         out_ff [NCH], nxt_out [NCH];
  logic [NCH-1:0]        upd_ff, nxt_upd;
  aos_gen_state_type     gst_ff [NCH], nxt_gst [NCH];
  logic [IW-1:0]         gix_ff [NCH], nxt_gix [NCH];
  logic [CW-1:0]         grep_ff [NCH], nxt_grep [NCH];
  aos_tab_type           tab_mem [NCH*DEPTH];
  logic [2:0]            t24_s, sy_s;
  logic [NCH-1:0]        flt_s1, flt_s2, flt_s3;

  logic                  req, go, wr, rd, t24_edge, sy_edge, rel_evt, gen_evt;
  logic                  us_tick, ms_tick, s_tick, unit_tick, rate_tick, wd_expire, tab_we;
  logic [15:0]           eff_rate;
  logic [STW-1:0]        st_set;

  // ==========================================================================
  // Avalon handshake: one wait state, request taken when waitrequest is low
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_ff;
  assign go                = req & ack_ff;
  assign wr                = go & avs_write_i;
  assign rd                = go & avs_read_i;
  assign avs_readdata_o    = rdata_ff;
  assign irq_o             = |(stat_ff & mask_ff);
  assign tab_we            = wr && (avs_address_i == REG_TAB_DATA);

  // ==========================================================================
  // Pin synchronisers; only the second stage and later feed logic
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t24_s  <= 3'h0;
      sy_s   <= 3'h0;
      flt_s1 <= '0;
      flt_s2 <= '0;
      flt_s3 <= '0;
    end else begin
      t24_s  <= {t24_s[1:0], trig24_i};
      sy_s   <= {sy_s[1:0], sync_trig_i};
      flt_s1 <= fault_i;
      flt_s2 <= flt_s1;
      flt_s3 <= flt_s2;
    end
  end

  assign t24_edge = t24_s[1] & ~t24_s[2];
  assign sy_edge  = sy_s[1] & ~sy_s[2];

  // ==========================================================================
  // Timebases
  assign us_tick   = (pre_us_ff == 8'(US_CYC - 1));
  assign ms_tick   = us_tick && (pre_ms_ff == 10'(UNIT_STEP - 1));
  assign s_tick    = ms_tick && (pre_s_ff == 10'(UNIT_STEP - 1));
  assign eff_rate  = (rate_ff < 16'(MIN_UPD_CYC)) ? 16'(MIN_UPD_CYC) : rate_ff;
  assign rate_tick = (rcnt_ff >= eff_rate - 16'h0001);
  always_comb begin
    unique case (aos_wdu_type'(wdu_ff))
      WDU_MS:  unit_tick = ms_tick;
      WDU_S:   unit_tick = s_tick;
      default: unit_tick = us_tick;
    endcase
  end
  assign wd_expire = wden_ff && unit_tick && (32'(wdcnt_ff) + 32'h1 >= 32'(wdper_ff));

  always_comb begin
    unique case (aos_rel_type'(rel_ff))
      REL_TRIG24: rel_evt = t24_edge;
      REL_SYNC:   rel_evt = sy_edge;
      default:    rel_evt = wr && (avs_address_i == REG_RELEASE);
    endcase
  end
  assign gen_evt = pick_trig(src_ff, t24_edge, sy_edge);

  // ==========================================================================
  // Table memory; written through the address pointer
  always_ff @(posedge clk_sys_i) begin
    if (tab_we) begin
      tab_mem[tab_at(tch_ff, tix_ff)] <= avs_writedata_i;
    end
  end

  // ==========================================================================
  // Next state of registers, generators and outputs
  always_comb begin
    logic          step;
    logic [CW-1:0] cnt;
    aos_tab_type   ent;
    nxt_ack = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_rel = rel_ff;
    nxt_wdu = wdu_ff;
    nxt_wden = wden_ff;
    nxt_wdper = wdper_ff;
    nxt_rate = rate_ff;
    nxt_cont = cont_ff;
    nxt_pace = pace_ff;
    nxt_src = src_ff;
    nxt_omode = omode_ff;
    nxt_tch = tch_ff;
    nxt_tix = tix_ff;
    nxt_mask = mask_ff;
    nxt_pmask = pmask_ff;
    nxt_upd = '0;
    nxt_last = last_ff;
    nxt_pval = pval_ff;
    nxt_out = out_ff;
    nxt_gst = gst_ff;
    nxt_gix = gix_ff;
    nxt_grep = grep_ff;
    st_set = '0;
    step = 1'b0;
    cnt = '0;
    ent = '0;
    nxt_pre_us = us_tick ? 8'h00 : pre_us_ff + 8'h01;
    nxt_pre_ms = ms_tick ? 10'h000 : (us_tick ? pre_ms_ff + 10'h001 : pre_ms_ff);
    nxt_pre_s  = s_tick ? 10'h000 : (ms_tick ? pre_s_ff + 10'h001 : pre_s_ff);
    nxt_rcnt   = rate_tick ? 16'h0000 : rcnt_ff + 16'h0001;
    nxt_wdcnt  = (go || wd_expire || !wden_ff) ? '0 : (unit_tick ? wdcnt_ff + 16'h0001 : wdcnt_ff);
    // Read data is loaded one edge before the master takes it
    if (req && !ack_ff && avs_read_i) begin
      unique case (avs_address_i)
        REG_CTRL:      nxt_rdata = 32'({wden_ff, wdu_ff, rel_ff});
        REG_WD_PERIOD: nxt_rdata = 32'(wdper_ff);
        REG_GEN_MODE:  nxt_rdata = 32'({src_ff, pace_ff, cont_ff});
        REG_GEN_RATE:  nxt_rdata = 32'(rate_ff);
        REG_OUT_MODE:  nxt_rdata = 32'(omode_ff);
        REG_TAB_ADDR:  nxt_rdata = 32'({tch_ff, 8'(tix_ff)});
        REG_TAB_LAST:  nxt_rdata = 32'(last_ff[tch_ff]);
        REG_STATUS:    nxt_rdata = 32'(stat_ff);
        REG_MASK:      nxt_rdata = 32'(mask_ff);
        REG_GEN_STATE: nxt_rdata = 32'({pmask_ff, 8'h00});
        default:       nxt_rdata = 32'h0000_0000;
      endcase
      if (avs_address_i == REG_GEN_STATE) begin
        for (int i = 0; i < NCH; i++) nxt_rdata[i] = (gst_ff[i] == GS_RUN);
      end
    end
    // Register writes
    if (wr) begin
      unique case (avs_address_i)
        REG_CTRL: begin
          nxt_rel  = avs_writedata_i[CTRL_REL_LSB +: 2];
          nxt_wdu  = avs_writedata_i[CTRL_WDU_LSB +: 2];
          nxt_wden = avs_writedata_i[CTRL_WDEN];
        end
        REG_WD_PERIOD: nxt_wdper = avs_writedata_i[WDW-1:0];
        REG_DIRECT: begin
          for (int i = 0; i < NCH; i++) begin
            if (avs_writedata_i[DIR_MASK_LSB + i]) begin
              nxt_pval[i]  = avs_writedata_i[DW-1:0];
              nxt_pmask[i] = 1'b1;
            end
          end
        end
        REG_GEN_MODE: begin
          nxt_cont = avs_writedata_i[NCH-1:0];
          nxt_pace = avs_writedata_i[MODE_PACE_LSB +: NCH];
          nxt_src  = avs_writedata_i[MODE_SRC];
        end
        REG_GEN_RATE: nxt_rate = avs_writedata_i[15:0];
        REG_OUT_MODE: nxt_omode = (HAS_CURRENT != 0) ? avs_writedata_i[NCH-1:0] : '0;
        REG_TAB_ADDR: begin
          nxt_tch = avs_writedata_i[TAB_CH_LSB +: 3];
          nxt_tix = avs_writedata_i[IW-1:0];
        end
        REG_TAB_DATA: nxt_tix = tix_ff + 1'b1;
        REG_TAB_LAST: nxt_last[avs_writedata_i[TAB_CH_LSB +: 3]] = avs_writedata_i[IW-1:0];
        REG_MASK:     nxt_mask = avs_writedata_i[STW-1:0];
        default: ;
      endcase
    end
    // release pending values to idle channels
    if (rel_evt) begin
      for (int i = 0; i < NCH; i++) begin
        if (pmask_ff[i] && gst_ff[i] == GS_IDLE) begin
          nxt_out[i]   = pval_ff[i];
          nxt_upd[i]   = 1'b1;
          nxt_pmask[i] = 1'b0;
        end
      end
    end
    // Generators, each with its own state
    for (int i = 0; i < NCH; i++) begin
      ent  = tab_mem[tab_at(3'(i), gix_ff[i])];
      cnt  = (ent.count == '0) ? 16'h0001 : ent.count;
      step = pace_ff[i] ? gen_evt : rate_tick;
      unique case (gst_ff[i])
        GS_IDLE: begin
          if (wr && avs_address_i == REG_GEN_CMD && avs_writedata_i[i]) begin
            nxt_gst[i]  = GS_RUN;
            nxt_gix[i]  = '0;
            nxt_grep[i] = '0;
            nxt_out[i]  = tab_mem[tab_at(3'(i), '0)].value;
            nxt_upd[i]  = 1'b1;
          end
        end
        GS_RUN: begin
          if (wr && avs_address_i == REG_GEN_CMD && avs_writedata_i[GEN_STOP_LSB + i]) begin
            nxt_gst[i] = GS_IDLE;
            nxt_out[i] = ZERO_CODE;
            nxt_upd[i] = 1'b1;
          end else if (step) begin
            if (grep_ff[i] + 16'h0001 < cnt) begin
              nxt_grep[i] = grep_ff[i] + 16'h0001;
            end else if (gix_ff[i] == last_ff[i]) begin
              nxt_grep[i] = '0;
              nxt_upd[i]  = 1'b1;
              if (cont_ff[i]) begin
                nxt_gix[i] = '0;
                nxt_out[i] = tab_mem[tab_at(3'(i), '0)].value;
              end else begin
                nxt_gst[i] = GS_IDLE;
                nxt_out[i] = ZERO_CODE;
                st_set[ST_DONE] = 1'b1;
              end
            end else begin
              nxt_grep[i] = '0;
              nxt_gix[i]  = gix_ff[i] + 1'b1;
              nxt_out[i]  = tab_mem[tab_at(3'(i), gix_ff[i] + 1'b1)].value;
              nxt_upd[i]  = 1'b1;
            end
          end
        end
      endcase
      if (flt_s2[i] && !flt_s3[i]) begin
        if (omode_ff[i]) st_set[ST_BREAK_LSB + i] = 1'b1;
        else st_set[i] = 1'b1;
      end
    end
    if (wd_expire) begin
      st_set[ST_WDOG] = 1'b1;
      nxt_pmask = '0;
      nxt_upd = '1;
      for (int i = 0; i < NCH; i++) begin
        nxt_out[i] = ZERO_CODE;
        nxt_gst[i] = GS_IDLE;
      end
    end
    // Read of status clears it; a new event in the same cycle wins
    nxt_stat = ((rd && avs_address_i == REG_STATUS) ? '0 : stat_ff) | st_set;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
      rel_ff <= REL_SOFT;
      wdu_ff <= WDU_US;
      wden_ff <= 1'b0;
      wdper_ff <= '0;
      wdcnt_ff <= '0;
      pre_us_ff <= '0;
      pre_ms_ff <= '0;
      pre_s_ff <= '0;
      rate_ff <= '0;
      rcnt_ff <= '0;
      cont_ff <= '0;
      pace_ff <= '0;
      src_ff <= 1'b0;
      omode_ff <= '0;
      tch_ff <= '0;
      tix_ff <= '0;
      stat_ff <= '0;
      mask_ff <= '0;
      pmask_ff <= '0;
      upd_ff <= '0;
      for (int i = 0; i < NCH; i++) begin
        last_ff[i] <= '0;
        pval_ff[i] <= '0;
        out_ff[i] <= ZERO_CODE;
        gst_ff[i] <= GS_IDLE;
        gix_ff[i] <= '0;
        grep_ff[i] <= '0;
      end
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      rel_ff <= nxt_rel;
      wdu_ff <= nxt_wdu;
      wden_ff <= nxt_wden;
      wdper_ff <= nxt_wdper;
      wdcnt_ff <= nxt_wdcnt;
      pre_us_ff <= nxt_pre_us;
      pre_ms_ff <= nxt_pre_ms;
      pre_s_ff <= nxt_pre_s;
      rate_ff <= nxt_rate;
      rcnt_ff <= nxt_rcnt;
      cont_ff <= nxt_cont;
      pace_ff <= nxt_pace;
      src_ff <= nxt_src;
      omode_ff <= nxt_omode;
      tch_ff <= nxt_tch;
      tix_ff <= nxt_tix;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      pmask_ff <= nxt_pmask;
      upd_ff <= nxt_upd;
      last_ff <= nxt_last;
      pval_ff <= nxt_pval;
      out_ff <= nxt_out;
      gst_ff <= nxt_gst;
      gix_ff <= nxt_gix;
      grep_ff <= nxt_grep;
    end
  end

  // Converter outputs straight from flops
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      dac_o[i].current_mode = omode_ff[i];
      dac_o[i].code         = out_ff[i];
    end
  end
  assign dac_update_o = upd_ff;

endmodule

// ===== verilog/aos_pkg.sv
// ==========================================================================
// Shared constants and types of the analog output sequencer
package aos_pkg;

  // ==========================================================================
  // Sizes
  localparam int NCH = 8;  // Output channels
  localparam int DW  = 16; // Converter code width
  localparam int CW  = 16; // Repeat count width
  localparam int WDW = 16; // Watchdog count width

  // ==========================================================================
  // Register byte offsets
  localparam logic [5:0] REG_CTRL      = 6'h00;
  localparam logic [5:0] REG_WD_PERIOD = 6'h04;
  localparam logic [5:0] REG_DIRECT    = 6'h08;
  localparam logic [5:0] REG_RELEASE   = 6'h0c;
  localparam logic [5:0] REG_GEN_CMD   = 6'h10;
  localparam logic [5:0] REG_GEN_MODE  = 6'h14;
  localparam logic [5:0] REG_GEN_RATE  = 6'h18;
  localparam logic [5:0] REG_OUT_MODE  = 6'h1c;
  localparam logic [5:0] REG_TAB_ADDR  = 6'h20;
  localparam logic [5:0] REG_TAB_DATA  = 6'h24;
  localparam logic [5:0] REG_TAB_LAST  = 6'h28;
  localparam logic [5:0] REG_STATUS    = 6'h30;
  localparam logic [5:0] REG_MASK      = 6'h34;
  localparam logic [5:0] REG_GEN_STATE = 6'h38;

  // ==========================================================================
  // Field positions
  localparam int CTRL_REL_LSB = 0;  // Release source, 2 bits
  localparam int CTRL_WDU_LSB = 2;  // Watchdog unit, 2 bits
  localparam int CTRL_WDEN    = 4;  // Watchdog enable
  localparam int DIR_MASK_LSB = 16; // Channel select of a direct value
  localparam int GEN_STOP_LSB = 8;  // Stop bits of the generator command
  localparam int MODE_PACE_LSB = 8; // Trigger-paced bits of the generator mode
  localparam int MODE_SRC     = 16; // Generator trigger source
  localparam int TAB_CH_LSB   = 16; // Channel field of table address
  localparam int ST_BREAK_LSB = 8;  // Line-break bits in status
  localparam int ST_WDOG      = 16; // Watchdog expiry in status
  localparam int ST_DONE      = 17; // A single-mode generator finished
  localparam int STW          = 18; // Status width

  // ==========================================================================
  // Timing
  localparam longint CLK_HZ     = 250_000_000;
  localparam int     CLK_NS     = 4;
  localparam int     US_NS      = 1000;
  localparam int     US_CYC     = US_NS / CLK_NS;
  localparam int     UNIT_STEP  = 1000; // us to ms, ms to s
  localparam longint UPD_MAX_HZ = 40_000;
  localparam int     MIN_UPD_CYC = int'((CLK_HZ + UPD_MAX_HZ - 1) / UPD_MAX_HZ);

  // ==========================================================================
  // Enumerations and carriers
  typedef enum logic [1:0] {REL_SOFT = 2'b00, REL_TRIG24 = 2'b01, REL_SYNC = 2'b10} aos_rel_type;
  typedef enum logic [1:0] {WDU_US = 2'b00, WDU_MS = 2'b01, WDU_S = 2'b10} aos_wdu_type;
  typedef enum logic [1:0] {GS_IDLE = 2'b01, GS_RUN = 2'b10} aos_gen_state_type;

  typedef struct packed {
    logic          current_mode;
    logic [DW-1:0] code;
  } aos_dac_type;

  typedef struct packed {
    logic [CW-1:0] count;
    logic [DW-1:0] value;
  } aos_tab_type;

endpackage

// ===== tb/aos_sequencer_chk.sv
`timescale 1ns/1ps
// ==========================================================================
// Port-level checks of the sequencer
module aos_sequencer_chk import aos_pkg::*; #(
  parameter logic [DW-1:0] ZERO_CODE = 16'h0000
) (
  input wire logic                  clk_sys_i,
  input wire logic                  reset_n_i,
  input wire logic [5:0]            avs_address_i,
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  input wire aos_dac_type [NCH-1:0] dac_o,
  input wire logic [NCH-1:0]        dac_update_o,
  input wire logic                  irq_o
);
  logic [NCH-1:0] nz;
  // Channels away from the zero code
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      nz[i] = dac_o[i].code != ZERO_CODE;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================================
  // Bus handshake: one wait state, then one acknowledged cycle
  sequence s_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_ack; (avs_read_i || avs_write_i) && !avs_waitrequest_o; endsequence
  sequence s_rd(logic [5:0] a); avs_read_i && !avs_waitrequest_o && avs_address_i == a; endsequence
  bus_one_wait_a: assert property (s_wait |=> s_ack) else $error("Bus answer late");
  bus_ack_once_a: assert property (s_ack |=> !s_ack) else $error("Bus ack held");
  bus_idle_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o) else $error("Idle wait");
  reset_zero_a: assert property ($rose(reset_n_i) |-> nz == '0 && dac_update_o == '0 && !irq_o)
    else $error("Outputs not zero after reset");
  direct_wo_a: assert property (s_rd(REG_DIRECT) |-> avs_readdata_o == 32'h0) else $error("Direct reads back");
  status_w_a: assert property (s_rd(REG_STATUS) |-> avs_readdata_o[31:STW] == '0) else $error("Status high bits");
  state_w_a: assert property (s_rd(REG_GEN_STATE) |-> avs_readdata_o[31:16] == '0) else $error("State high bits");
  // A code never moves without its load strobe
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    code_pulse_a: assert property ($changed(dac_o[i].code) |-> dac_update_o[i]) else $error("Silent change");
  end
endmodule

// ===== tb/aos_dac_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Converter bank: each channel takes its code on its load strobe
module aos_dac_model import aos_pkg::*; (
  input  wire logic                  clk_sys_i,
  input  wire aos_dac_type [NCH-1:0] dac_i,
  input  wire logic [NCH-1:0]        load_i,
  output logic [NCH-1:0][DW-1:0]     lat_o
);
  // Power-up content is unknown until the first load
  // converter takes value
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < NCH; i++) begin
      if (load_i[i]) begin
        lat_o[i] <= dac_i[i].code;
      end
    end
  end
endmodule

// ===== tb/tb_analog_output_sequencer.sv
`timescale 1ns/1ps
module tb_analog_output_sequencer import aos_pkg::*;;
  localparam logic [DW-1:0] Z = 16'h8000; // Offset-binary zero catches a hard-wired 0
  localparam int            M = MIN_UPD_CYC;
  logic                     clk, reset_n, rd, wr, wreq, trig, sync, irq;
  logic [5:0]               addr;
  logic [31:0]              wdata, rdata, q, v;
  logic [31:0]              seed = 32'h46e9;
  logic [NCH-1:0]           fault, upd, m;
  aos_dac_type [NCH-1:0]    dac;
  logic [NCH-1:0][DW-1:0]   lat;
  logic [DW-1:0]            exp_code [NCH];
  logic [DW-1:0]            seq [4] = '{16'h2222, 16'h2222, 16'h1111, 16'h2222};
  int                       fails = 0, n_compared = 0, cyc = 0, n;
  aos_sequencer #(.ZERO_CODE(Z)) DUT (.clk_sys_i(clk), .reset_n_i(reset_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .trig24_i(trig), .sync_trig_i(sync), .fault_i(fault),
    .dac_o(dac), .dac_update_o(upd), .irq_o(irq));
  aos_dac_model u_dac (.clk_sys_i(clk), .dac_i(dac), .load_i(upd), .lat_o(lat));
  // ==========================================================================
  // Helpers
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Xorshift source of random stimulus
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Master holds the request until a rising edge samples waitrequest low, takes data there
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wr <= w; rd <= !w; wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 0; wr <= 0;
  endtask
  task settle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task chk_dac;
    for (int i = 0; i < NCH; i++) chk(32'(dac[i].code), 32'(exp_code[i]));
  endtask
  task pulse(input logic t24);
    @(posedge clk);
    if (t24) trig <= 1; else sync <= 1;
    repeat (2) @(posedge clk);
    trig <= 0; sync <= 0;
    settle(8);
  endtask
  // Counts cycles up to the next load strobe of channel 0, bounded
  task wait_upd;
    n = 0;
    do begin @(negedge clk); n++; end while (upd[0] !== 1'b1 && n < 20000);
  endtask
  task print_verdict;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin clk = 0; forever #2 clk = ~clk; end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin fails++; print_verdict(); end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    reset_n = 0; rd = 0; wr = 0; addr = 0; wdata = 0; trig = 0; sync = 0; fault = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1;
    for (int i = 0; i < NCH; i++) exp_code[i] = Z;
    settle(0);
    chk_dac();
    chk(32'(irq), 0);
    bus(0, REG_CTRL, 0); chk(q, 0);
    bus(0, 6'h3c, 0); chk(q, 0);
    // Direct values under each release source; a soft release or trig24 pulse under another source must not release
    for (int s = 0; s < 3; s++) begin
      seed = xs(seed);
      v = seed; m = v[23:16] | 8'(1 << s);
      bus(1, REG_CTRL, 32'(s));
      bus(1, REG_DIRECT, {8'h0, m, v[15:0]});
      if (s != 0) bus(1, REG_RELEASE, 0);
      if (s != 1) pulse(1);
      settle(0); chk_dac();
      bus(0, REG_GEN_STATE, 0); chk(32'(q[15:8]), 32'(m));
      if (s == 0) bus(1, REG_RELEASE, 0); else pulse(s == 1);
      for (int i = 0; i < NCH; i++) if (m[i]) exp_code[i] = v[15:0];
      settle(2); chk_dac();
      for (int i = 0; i < NCH; i++) if (m[i]) chk(32'(lat[i]), 32'(v[15:0]));
    end
    // Faults: line break in current mode, short in voltage mode, masking
    bus(1, REG_OUT_MODE, 32'h4); bus(1, REG_MASK, 32'h400);
    settle(4); chk(32'(dac[2].current_mode), 1);
    @(posedge clk); fault <= 8'h0c; settle(8); chk(32'(irq), 1);
    bus(0, REG_STATUS, 0); chk(q, 32'h408);
    settle(2); chk(32'(irq), 0);
    @(posedge clk); fault <= 8'h0; settle(4);
    @(posedge clk); fault <= 8'h08; settle(8); chk(32'(irq), 0);
    bus(0, REG_STATUS, 0); chk(q, 32'h8);
    // Single mode, rate paced at the clamped minimum interval
    bus(1, REG_TAB_ADDR, 0); bus(1, REG_TAB_DATA, 32'h0001_aaaa); bus(1, REG_TAB_DATA, 32'h0002_bbbb);
    bus(1, REG_TAB_DATA, 32'h0001_cccc);
    bus(1, REG_TAB_LAST, 2); bus(1, REG_GEN_MODE, 0); bus(1, REG_GEN_RATE, 1);
    bus(1, REG_MASK, 32'(1) << ST_DONE); bus(1, REG_GEN_CMD, 1);
    // First step falls at an unknown phase of the free-running rate counter, so time later ones
    wait_upd(); chk(32'(dac[0].code), 32'haaaa);
    wait_upd(); chk(32'(dac[0].code), 32'hbbbb);
    wait_upd(); chk(32'(n >= 2 * M - 8 && n <= 2 * M + 8), 1);
    chk(32'(dac[0].code), 32'hcccc);
    wait_upd(); chk(32'(n >= M - 8 && n <= M + 8), 1);
    exp_code[0] = Z; chk_dac();
    settle(2); chk(32'(irq), 1);
    bus(0, REG_STATUS, 0); chk(q, 32'(1) << ST_DONE);
    // Continuous mode on channel 1, stepped by the sync trigger only
    bus(1, REG_TAB_ADDR, 32'h10000); bus(1, REG_TAB_DATA, 32'h0001_1111); bus(1, REG_TAB_DATA, 32'h0002_2222);
    bus(1, REG_TAB_LAST, 32'h10001); bus(1, REG_GEN_MODE, 32'h10202); bus(1, REG_GEN_CMD, 2);
    settle(2); exp_code[1] = 16'h1111; chk_dac();
    pulse(1); chk_dac();
    for (int k = 0; k < 4; k++) begin
      pulse(0); exp_code[1] = seq[k]; chk_dac();
    end
    bus(1, REG_GEN_CMD, 32'h200); settle(2); exp_code[1] = Z; chk_dac();
    bus(0, REG_GEN_STATE, 0); chk(32'(q[7:0]), 0);
    // Watchdog kept alive by bus traffic, then left to expire
    bus(1, REG_CTRL, 0); bus(1, REG_DIRECT, 32'h0008_5a5a); bus(1, REG_RELEASE, 0);
    exp_code[3] = 16'h5a5a;
    bus(1, REG_WD_PERIOD, 2); bus(1, REG_CTRL, 32'(1) << CTRL_WDEN);
    repeat (5) begin settle(200); bus(0, REG_CTRL, 0); end
    settle(0); chk_dac();
    settle(1000);
    for (int i = 0; i < NCH; i++) exp_code[i] = Z;
    chk_dac();
    bus(0, REG_STATUS, 0); chk(q, 32'(1) << ST_WDOG);
    bus(1, REG_CTRL, 0);
    print_verdict();
  end
endmodule
bind aos_sequencer aos_sequencer_chk #(.ZERO_CODE(ZERO_CODE)) u_chk (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .dac_o(dac_o), .dac_update_o(dac_update_o), .irq_o(irq_o));
